// File: core/can_selective_wakeup_filter.sv
// What this block does
// - Mode field: 00 offline, 01/10 active, 11 listen; only in chip mode 111.
// - FD tolerance 1 ignores FD frames; 0 raises frame error event but gives no wake.
// - Configuration-valid at 0 means only the standard wake pattern wakes.
// - Any write to a selective configuration register clears configuration-valid.
// - Frame wake only when enable, configuration-valid and bus-wake enable are all 1.
// - Selective wake starts disabled after power-on.
// - Status bit 7 is 1 only while the transceiver is active.
// - Status bit 6 is error event or invalid config; bit 5 mirrors valid.
// - Status bit 4 shows the oscillator running at target frequency.
// - Status bit 3 is 1 after bus silence timeout, 0 with activity.
// - Status bit 1 shows supply undervoltage, only while mode field is 01.
// - Status bit 0 shows transmitter disabled by a transmit-dominant time-out.
// - Bit rate codes 000 to 011 give 50k,100k,125k,250k; 111 gives 1000k; 100, 101 and 110 give 500k.
// - Identifier format bit selects 11-bit or 29-bit identifier matching.
// - Standard id from 0x2a[4:0] and 0x29[7:2]; extended uses 0x27 to 0x2a.
// - Identifier mask bit 1 makes that bit don't-care; 0 requires equality.
// - Evaluate bit 0: id plus good CRC wakes; 1 also checks length and data.
// - Length mismatch rejects; needs a received 1 under a mask 1 bit unless length is 0.
// - Data mask 7 covers the most significant, first received data byte.
// - Only data frames wake; remote frames never do.
// - Error counter up on stuff/CRC error, down on good frame; 32 raises event.
// - Expected length codes 1001 to 1111 mean eight bytes.
`timescale 1ns/1ns
module can_selective_wakeup_filter #(
    parameter int SILENCE_CYCLES =
        wake_filter_pkg::SILENCE_TIMEOUT_US * wake_filter_pkg::CLK_FREQ_KHZ / 1000
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Chip state
    input wire logic [2:0] chip_operating_mode_in,
    input wire logic bus_wake_enable_in,
    input wire logic sleep_mode_in,
    input wire logic fde_clear_in,
    // Analog and pin inputs
    input wire logic bus_rx_in,
    input wire logic osc_ok_in,
    input wire logic supply_undervoltage_in,
    input wire logic transmit_timeout_in,
    // Results
    output logic [1:0] transceiver_mode_out,
    output logic selective_active_out,
    output logic selective_wake_frame_out,
    output logic frame_detect_error_event_out,
    output logic standby_request_out
);
    import wake_filter_pkg::*;

    typedef struct packed {
        logic [3:0] sync1, sync2, sync3, stable;
        logic rx_prev, fd_tol, cfg_valid, sel_en;
        logic [1:0] tmode;
        logic [2:0] rate;
        logic [28:0] id_cfg, mask_cfg;
        logic ide_sel, data_eval;
        logic [3:0] dlc_cfg;
        logic [63:0] dmask;
        phase_e phase;
        logic [11:0] tq;
        logic [5:0] pos;
        logic [2:0] run;
        logic last;
        logic [14:0] crc;
        logic [28:0] rx_id;
        logic ide_rx, rtr_rx;
        logic [3:0] dlc_rx;
        logic [6:0] cnt;
        logic [63:0] data_sr;
        logic [3:0] idle_cnt;
        logic [5:0] err_cnt;
        logic fde_flag;
        logic [31:0] sil_cnt;
        logic silent;
        logic [7:0] rdata;
        logic [1:0] mode;
        logic active, wake, fde, standby;
    } state_s;

    state_s s_reg;
    state_s s_next;

    always_comb begin
        logic b, smp, fall, stuff_err, crc_end, frame_ok, id_hit, data_hit, err_ev, fde_ev, wake;
        logic [14:0] crc_new;
        logic [3:0] dlc_new, rx_bytes, cfg_bytes;
        logic [11:0] blen;
        logic [28:0] diff;
        logic [63:0] mvec;
        logic [7:0] status;
        s_next = s_reg;
        stuff_err = 1'b0;
        crc_end = 1'b0;
        fde_ev = 1'b0;
        crc_new = s_reg.crc;
        dlc_new = s_reg.dlc_rx;

        // Change taken once stages two and three agree
        s_next.sync1 = {bus_rx_in, osc_ok_in, supply_undervoltage_in, transmit_timeout_in};
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        for (int i = 0; i < 4; i++) begin
            if (s_reg.sync2[i] == s_reg.sync3[i]) begin
                s_next.stable[i] = s_reg.sync3[i];
            end
        end
        b = s_reg.stable[3];
        s_next.rx_prev = b;
        fall = s_reg.rx_prev & ~b;

        // Hard resync on each falling edge
        blen = bit_cycles(s_reg.rate);
        if (fall || s_reg.tq >= blen - 12'h1) begin
            s_next.tq = 12'h0;
        end else begin
            s_next.tq = s_reg.tq + 12'h1;
        end
        smp = (s_reg.tq == (blen >> 1)) && !fall;

        case (s_reg.phase)
            PH_WAIT_IDLE: begin
                if (smp) begin
                    if (!b) begin
                        s_next.idle_cnt = 4'h0;
                    end else if (s_reg.idle_cnt == IDLE_BITS - 4'h1) begin
                        s_next.phase = PH_IDLE;
                    end else begin
                        s_next.idle_cnt = s_reg.idle_cnt + 4'h1;
                    end
                end
            end
            PH_IDLE: begin
                if (fall) begin
                    s_next.phase = PH_HEAD;
                    s_next.pos = 6'h0;
                    s_next.run = 3'h0;
                    s_next.last = 1'b1;
                    s_next.crc = 15'h0;
                    s_next.rx_id = 29'h0;
                    s_next.ide_rx = 1'b0;
                    s_next.rtr_rx = 1'b0;
                    s_next.dlc_rx = 4'h0;
                    s_next.data_sr = 64'h0;
                end
            end
            PH_HEAD, PH_DATA, PH_CRC: begin
                if (smp) begin
                    if (s_reg.run == STUFF_RUN) begin
                        // Stuff bit: dropped, but a sixth equal bit is an error
                        if (b == s_reg.last) begin
                            stuff_err = 1'b1;
                        end else begin
                            s_next.run = 3'h1;
                            s_next.last = b;
                        end
                    end else begin
                        s_next.run = (b == s_reg.last) ? s_reg.run + 3'h1 : 3'h1;
                        s_next.last = b;
                        crc_new = {s_reg.crc[13:0], 1'b0} ^ ((b ^ s_reg.crc[14]) ? CRC_POLY : 15'h0);
                        s_next.crc = crc_new;
                        if (s_reg.phase == PH_HEAD) begin
                            s_next.pos = s_reg.pos + 6'h1;
                            if (s_reg.pos == 6'h0 && b) begin
                                s_next.phase = PH_IDLE;
                            end else if ((s_reg.pos >= 6'd1 && s_reg.pos <= 6'd11) ||
                                         (s_reg.ide_rx && s_reg.pos >= 6'd14 &&
                                          s_reg.pos <= 6'd31)) begin
                                s_next.rx_id = {s_reg.rx_id[27:0], b};
                            end else if (s_reg.pos == 6'd12 ||
                                         (s_reg.ide_rx && s_reg.pos == 6'd32)) begin
                                s_next.rtr_rx = b;
                            end else if (s_reg.pos == 6'd13) begin
                                s_next.ide_rx = b;
                            end else if ((!s_reg.ide_rx && s_reg.pos == 6'd14) ||
                                         (s_reg.ide_rx && s_reg.pos == 6'd33)) begin
                                if (b) begin
                                    // Flexible-data-rate frame: never decoded further
                                    s_next.phase = PH_WAIT_IDLE;
                                    s_next.idle_cnt = 4'h0;
                                    fde_ev = !s_reg.fd_tol;
                                end
                            end else if ((!s_reg.ide_rx && s_reg.pos >= 6'd15) ||
                                         (s_reg.ide_rx && s_reg.pos >= 6'd35)) begin
                                dlc_new = {s_reg.dlc_rx[2:0], b};
                                s_next.dlc_rx = dlc_new;
                                if (s_reg.pos == (s_reg.ide_rx ? 6'd38 : 6'd18)) begin
                                    rx_bytes = (dlc_new > MAX_BYTES) ? MAX_BYTES : dlc_new;
                                    if (s_reg.rtr_rx || rx_bytes == 4'h0) begin
                                        s_next.phase = PH_CRC;
                                        s_next.cnt = CRC_BITS;
                                    end else begin
                                        s_next.phase = PH_DATA;
                                        s_next.cnt = {rx_bytes, 3'b000};
                                    end
                                end
                            end
                        end else if (s_reg.phase == PH_DATA) begin
                            s_next.data_sr = {s_reg.data_sr[62:0], b};
                            s_next.cnt = s_reg.cnt - 7'h1;
                            if (s_reg.cnt == 7'h1) begin
                                s_next.phase = PH_CRC;
                                s_next.cnt = CRC_BITS;
                            end
                        end else begin
                            s_next.cnt = s_reg.cnt - 7'h1;
                            if (s_reg.cnt == 7'h1) begin
                                crc_end = 1'b1;
                                s_next.phase = PH_WAIT_IDLE;
                                s_next.idle_cnt = 4'h0;
                            end
                        end
                    end
                    if (stuff_err) begin
                        s_next.phase = PH_WAIT_IDLE;
                        s_next.idle_cnt = 4'h0;
                    end
                end
            end
            default: begin
                s_next.phase = PH_WAIT_IDLE;
                s_next.idle_cnt = 4'h0;
            end
        endcase

        // Frame acceptance
        if (s_reg.ide_sel) begin
            diff = (s_reg.rx_id ^ s_reg.id_cfg) & ~s_reg.mask_cfg;
        end else begin
            diff = {18'h0, (s_reg.rx_id[10:0] ^ s_reg.id_cfg[28:18]) &
                    ~s_reg.mask_cfg[28:18]};
        end
        id_hit = (s_reg.ide_rx == s_reg.ide_sel) && (diff == 29'h0);
        rx_bytes = (s_reg.dlc_rx > MAX_BYTES) ? MAX_BYTES : s_reg.dlc_rx;
        cfg_bytes = (s_reg.dlc_cfg > MAX_BYTES) ? MAX_BYTES : s_reg.dlc_cfg;
        // First received byte sits highest and meets data mask 7
        mvec = s_reg.dmask >> (7'd64 - {rx_bytes, 3'b000});
        if (rx_bytes == 4'h0) begin
            data_hit = 1'b1;
        end else begin
            data_hit = |(s_reg.data_sr & mvec);
        end
        frame_ok = crc_end && (crc_new == 15'h0);
        wake = frame_ok && !s_reg.rtr_rx && id_hit &&
               (!s_reg.data_eval || ((rx_bytes == cfg_bytes) && data_hit));

        // Saturating error counter
        err_ev = stuff_err || (crc_end && crc_new != 15'h0);
        if (err_ev) begin
            if (s_reg.err_cnt < ERR_LIMIT) begin
                s_next.err_cnt = s_reg.err_cnt + 6'h1;
                if (s_reg.err_cnt == ERR_LIMIT - 6'h1) begin
                    fde_ev = 1'b1;
                end
            end
        end else if (frame_ok && s_reg.err_cnt != 6'h0) begin
            s_next.err_cnt = s_reg.err_cnt - 6'h1;
        end

        // Decoder parked unless selective wake fully armed
        s_next.active = s_reg.sel_en && s_reg.cfg_valid && bus_wake_enable_in;
        if (!s_reg.active) begin
            s_next.phase = PH_WAIT_IDLE;
            s_next.idle_cnt = 4'h0;
            wake = 1'b0;
            fde_ev = 1'b0;
        end

        s_next.wake = wake;
        s_next.fde = fde_ev;
        s_next.standby = fde_ev && sleep_mode_in;
        // Set wins over a simultaneous clear
        s_next.fde_flag = fde_ev || (s_reg.fde_flag && !fde_clear_in);

        // Bus silence
        if (b != s_reg.rx_prev) begin
            s_next.sil_cnt = 32'h0;
            s_next.silent = 1'b0;
        end else if (s_reg.sil_cnt < 32'(SILENCE_CYCLES)) begin
            s_next.sil_cnt = s_reg.sil_cnt + 32'h1;
        end else begin
            s_next.silent = 1'b1;
        end

        // Transceiver mode
        if (chip_operating_mode_in != CHIP_MODE_NORMAL) begin
            s_next.mode = XCVR_OFFLINE;
        end else begin
            case (s_reg.tmode)
                2'h0: s_next.mode = XCVR_OFFLINE;
                2'h3: s_next.mode = XCVR_LISTEN;
                default: s_next.mode = XCVR_ACTIVE;
            endcase
        end

        status = 8'h0;
        status[ST_ACTIVE_BIT] = (s_reg.mode == XCVR_ACTIVE) && !s_reg.stable[0];
        status[ST_ERROR_BIT] = s_reg.fde_flag || !s_reg.cfg_valid;
        status[ST_CONFIG_OK_BIT] = s_reg.cfg_valid;
        status[ST_OSC_OK_BIT] = s_reg.stable[2];
        status[ST_SILENCE_BIT] = s_reg.silent;
        status[ST_UNDERVOLT_BIT] = s_reg.stable[1] && (s_reg.tmode == XCVR_ACTIVE);
        status[ST_TX_TIMEOUT_BIT] = s_reg.stable[0];

        // Register reads, answered one cycle after the strobe
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_XCVR_CTRL: s_next.rdata = {1'b0, s_reg.fd_tol, s_reg.cfg_valid,
                                                s_reg.sel_en, 2'b00, s_reg.tmode};
                ADDR_XCVR_STATUS: s_next.rdata = status;
                ADDR_BIT_RATE: s_next.rdata = {5'h0, s_reg.rate};
                ADDR_ID_BYTE0: s_next.rdata = s_reg.id_cfg[7:0];
                ADDR_ID_BYTE1: s_next.rdata = s_reg.id_cfg[15:8];
                ADDR_ID_BYTE2: s_next.rdata = s_reg.id_cfg[23:16];
                ADDR_ID_BYTE3: s_next.rdata = {3'h0, s_reg.id_cfg[28:24]};
                ADDR_MASK_BYTE0: s_next.rdata = s_reg.mask_cfg[7:0];
                ADDR_MASK_BYTE1: s_next.rdata = s_reg.mask_cfg[15:8];
                ADDR_MASK_BYTE2: s_next.rdata = s_reg.mask_cfg[23:16];
                ADDR_MASK_BYTE3: s_next.rdata = {3'h0, s_reg.mask_cfg[28:24]};
                ADDR_FRAME_CTRL: s_next.rdata = {s_reg.ide_sel, s_reg.data_eval, 2'b00,
                                                 s_reg.dlc_cfg};
                default: begin
                    if (reg_addr_in >= ADDR_DATA_MASK0 && reg_addr_in <= ADDR_DATA_MASK7) begin
                        s_next.rdata = s_reg.dmask[{reg_addr_in[2:0], 3'b000} +: 8];
                    end else begin
                        s_next.rdata = 8'h0;
                    end
                end
            endcase
        end

        // Configuration writes invalidate the setup
        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_XCVR_CTRL: begin
                    s_next.tmode = reg_wdata_in[1:0];
                    s_next.sel_en = reg_wdata_in[CTRL_SEL_EN_BIT];
                    s_next.cfg_valid = reg_wdata_in[CTRL_VALID_BIT];
                    s_next.fd_tol = reg_wdata_in[CTRL_FD_TOL_BIT];
                end
                ADDR_BIT_RATE: s_next.rate = reg_wdata_in[2:0];
                ADDR_ID_BYTE0: s_next.id_cfg[7:0] = reg_wdata_in;
                ADDR_ID_BYTE1: s_next.id_cfg[15:8] = reg_wdata_in;
                ADDR_ID_BYTE2: s_next.id_cfg[23:16] = reg_wdata_in;
                ADDR_ID_BYTE3: s_next.id_cfg[28:24] = reg_wdata_in[4:0];
                ADDR_MASK_BYTE0: s_next.mask_cfg[7:0] = reg_wdata_in;
                ADDR_MASK_BYTE1: s_next.mask_cfg[15:8] = reg_wdata_in;
                ADDR_MASK_BYTE2: s_next.mask_cfg[23:16] = reg_wdata_in;
                ADDR_MASK_BYTE3: s_next.mask_cfg[28:24] = reg_wdata_in[4:0];
                ADDR_FRAME_CTRL: begin
                    s_next.ide_sel = reg_wdata_in[FC_IDE_BIT];
                    s_next.data_eval = reg_wdata_in[FC_EVAL_BIT];
                    s_next.dlc_cfg = reg_wdata_in[3:0];
                end
                default: begin
                    if (reg_addr_in >= ADDR_DATA_MASK0 && reg_addr_in <= ADDR_DATA_MASK7) begin
                        s_next.dmask[{reg_addr_in[2:0], 3'b000} +: 8] = reg_wdata_in;
                    end
                end
            endcase
            if ((reg_addr_in >= ADDR_BIT_RATE && reg_addr_in <= ADDR_FRAME_CTRL) ||
                (reg_addr_in >= ADDR_DATA_MASK0 && reg_addr_in <= ADDR_DATA_MASK7)) begin
                s_next.cfg_valid = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.sync1 <= SYNC_RESET;
            s_reg.sync2 <= SYNC_RESET;
            s_reg.sync3 <= SYNC_RESET;
            s_reg.stable <= SYNC_RESET;
            s_reg.rx_prev <= 1'b1;
            s_reg.rate <= BIT_RATE_RESET;
            s_reg.phase <= PH_WAIT_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_out = s_reg.rdata;
    assign transceiver_mode_out = s_reg.mode;
    assign selective_active_out = s_reg.active;
    assign selective_wake_frame_out = s_reg.wake;
    assign frame_detect_error_event_out = s_reg.fde;
    assign standby_request_out = s_reg.standby;

endmodule : can_selective_wakeup_filter

// File: core/wake_filter_pkg.sv
package wake_filter_pkg;

    // Register map
    localparam logic [6:0] ADDR_XCVR_CTRL = 7'h20;
    localparam logic [6:0] ADDR_XCVR_STATUS = 7'h22;
    localparam logic [6:0] ADDR_BIT_RATE = 7'h26;
    localparam logic [6:0] ADDR_ID_BYTE0 = 7'h27;
    localparam logic [6:0] ADDR_ID_BYTE1 = 7'h28;
    localparam logic [6:0] ADDR_ID_BYTE2 = 7'h29;
    localparam logic [6:0] ADDR_ID_BYTE3 = 7'h2a;
    localparam logic [6:0] ADDR_MASK_BYTE0 = 7'h2b;
    localparam logic [6:0] ADDR_MASK_BYTE1 = 7'h2c;
    localparam logic [6:0] ADDR_MASK_BYTE2 = 7'h2d;
    localparam logic [6:0] ADDR_MASK_BYTE3 = 7'h2e;
    localparam logic [6:0] ADDR_FRAME_CTRL = 7'h2f;
    localparam logic [6:0] ADDR_DATA_MASK0 = 7'h68;
    localparam logic [6:0] ADDR_DATA_MASK7 = 7'h6f;

    // Control register fields
    localparam int CTRL_FD_TOL_BIT = 6, CTRL_VALID_BIT = 5, CTRL_SEL_EN_BIT = 4;
    // Status register fields
    localparam int ST_ACTIVE_BIT = 7, ST_ERROR_BIT = 6, ST_CONFIG_OK_BIT = 5;
    localparam int ST_OSC_OK_BIT = 4, ST_SILENCE_BIT = 3;
    localparam int ST_UNDERVOLT_BIT = 1, ST_TX_TIMEOUT_BIT = 0;
    // Frame control fields
    localparam int FC_IDE_BIT = 7, FC_EVAL_BIT = 6;

    // Reset values
    localparam logic [2:0] BIT_RATE_RESET = 3'h5;
    localparam logic [3:0] SYNC_RESET = 4'h8;

    // Mode codes
    localparam logic [2:0] CHIP_MODE_NORMAL = 3'h7;
    localparam logic [1:0] XCVR_OFFLINE = 2'h0;
    localparam logic [1:0] XCVR_ACTIVE = 2'h1;
    localparam logic [1:0] XCVR_LISTEN = 2'h3;

    // Timing
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int RATE_50K = 50, RATE_100K = 100, RATE_125K = 125, RATE_250K = 250;
    localparam int RATE_500K = 500, RATE_1000K = 1000;
    localparam int SILENCE_TIMEOUT_US = 1000;

    // Frame decoding
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [6:0] CRC_BITS = 7'h0f;
    localparam logic [3:0] IDLE_BITS = 4'ha;
    localparam logic [5:0] ERR_LIMIT = 6'h20;
    localparam logic [3:0] MAX_BYTES = 4'h8;

    typedef enum logic [2:0] {PH_WAIT_IDLE, PH_IDLE, PH_HEAD, PH_DATA, PH_CRC} phase_e;

    function automatic logic [11:0] bit_cycles(input logic [2:0] code);
        case (code)
            3'h0: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_50K);
            3'h1: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_100K);
            3'h2: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_125K);
            3'h3: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_250K);
            3'h7: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_1000K);
            default: bit_cycles = 12'(CLK_FREQ_KHZ / RATE_500K);
        endcase
    endfunction : bit_cycles

endpackage : wake_filter_pkg

// File: testbench/can_node.sv
`timescale 1ns/1ns
module can_node (
    // Bus side
    input wire logic clk_in,
    output logic rx_out
);
    initial rx_out = 1'b1;
    task automatic put(input logic v, input int bt);
        rx_out = v;
        repeat (bt) @(negedge clk_in);
    endtask : put
    // Stuffed MSB first with CRC; trailing recessive covers EOF and intermission
    task automatic send(input logic [127:0] f, input int n, input int bt);
        logic [14:0] crc;
        logic last;
        int run;
        crc = 15'h0;
        last = 1'b1;
        run = 0;
        for (int i = n - 1; i >= 0; i--)
            crc = {crc[13:0], 1'b0} ^ ((f[i] ^ crc[14]) ? 15'h4599 : 15'h0);
        f = (f << 15) | 128'(crc);
        for (int i = n + 14; i >= 0; i--) begin
            if (run == 5) begin
                last = !last;
                run = 1;
                put(last, bt);
            end
            run = (f[i] == last) ? run + 1 : 1;
            last = f[i];
            put(last, bt);
        end
        put(1'b1, bt * 12);
    endtask : send
endmodule : can_node

// File: testbench/can_selective_wakeup_filter_bench.sv
`timescale 1ns/1ns
module can_selective_wakeup_filter_bench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bwe = 1'b0, slp = 1'b0, tto = 1'b0;
    logic rx, act, wk, fde, sb;
    logic [2:0] cm = 3'h7;
    logic [6:0] a = 7'h0;
    logic [7:0] wd = 8'h0, q;
    logic [1:0] md;
    int num_errors = 0, check_count = 0, wks = 0, fds = 0, sbs = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (wk === 1'b1) wks++;
        if (fde === 1'b1) fds++;
        if (sb === 1'b1) sbs++;
    end
    can_selective_wakeup_filter #(.SILENCE_CYCLES(200)) can_selective_wakeup_filter_inst (
        .sys_clk_in(clk), .rst_in(rst), .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(q), .chip_operating_mode_in(cm),
        .bus_wake_enable_in(bwe), .sleep_mode_in(slp), .fde_clear_in(1'b0), .bus_rx_in(rx),
        .osc_ok_in(1'b1), .supply_undervoltage_in(1'b1), .transmit_timeout_in(tto),
        .transceiver_mode_out(md), .selective_active_out(act), .selective_wake_frame_out(wk),
        .frame_detect_error_event_out(fde), .standby_request_out(sb));
    can_node can_node_inst (.clk_in(clk), .rx_out(rx));
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wreg(logic [6:0] ad, logic [7:0] v);
        @(negedge clk);
        a = ad;
        wd = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rreg(logic [6:0] ad, logic [7:0] e);
        @(negedge clk);
        a = ad;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("register", e, q);
    endtask : rreg
    task automatic tx(logic [127:0] f, int n, int ew, int ef);
        int w0 = wks;
        int f0 = fds;
        can_node_inst.send(f, n, 100);
        chk("wake", 8'(ew), 8'(wks - w0));
        chk("error event", 8'(ef), 8'(fds - f0));
    endtask : tx
    task automatic t_reset();
        rreg(7'h20, 8'h00);
        rreg(7'h26, 8'h05);
        repeat (4) @(negedge clk);
        rreg(7'h22, 8'h50);
        rreg(7'h21, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_config();
        bwe = 1'b1;
        wreg(7'h2a, 8'h12);
        wreg(7'h29, 8'h40);
        wreg(7'h2d, 8'h0c);
        wreg(7'h2f, 8'h41);
        wreg(7'h6f, 8'h05);
        wreg(7'h26, 8'h07);
        wreg(7'h20, 8'h30);
        repeat (300) @(negedge clk);
        rreg(7'h22, 8'h38);
        chk("active", 8'h01, {7'h0, act});
        $display("t_config done");
    endtask : t_config
    task automatic t_frames();
        repeat (1000) @(negedge clk);
        tx({1'b0, 11'h491, 3'h0, 4'h1, 8'h04}, 27, 1, 0);
        tx({1'b0, 11'h494, 3'h0, 4'h1, 8'h04}, 27, 0, 0);
        tx({1'b0, 11'h491, 3'h0, 4'h1, 8'h02}, 27, 0, 0);
        tx({1'b0, 11'h491, 3'h4, 4'h1}, 19, 0, 0);
        wreg(7'h2f, 8'h01);
        rreg(7'h22, 8'h58);
        wreg(7'h20, 8'h30);
        repeat (1100) @(negedge clk);
        tx({1'b0, 11'h491, 3'h0, 4'h1, 8'h02}, 27, 1, 0);
        $display("t_frames done");
    endtask : t_frames
    task automatic t_mode();
        wreg(7'h20, 8'h31);
        repeat (4) @(negedge clk);
        chk("mode", 8'h01, {6'h0, md});
        rreg(7'h22, 8'hba);
        tto = 1'b1;
        repeat (5) @(negedge clk);
        rreg(7'h22, 8'h3b);
        tto = 1'b0;
        cm = 3'h3;
        repeat (3) @(negedge clk);
        chk("mode", 8'h00, {6'h0, md});
        cm = 3'h7;
        wreg(7'h20, 8'h30);
        $display("t_mode done");
    endtask : t_mode
    task automatic t_fd();
        int s0 = sbs;
        slp = 1'b1;
        tx({1'b0, 11'h491, 3'h1, 4'h1, 8'h04}, 27, 0, 1);
        chk("standby", 8'h01, 8'(sbs - s0));
        slp = 1'b0;
        wreg(7'h20, 8'h70);
        repeat (1100) @(negedge clk);
        tx({1'b0, 11'h491, 3'h1, 4'h1, 8'h04}, 27, 0, 0);
        $display("t_fd done");
    endtask : t_fd
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_config();
        t_frames();
        t_mode();
        t_fd();
        tally_and_finish();
    end
    // Run needs about 43k cycles
    initial begin
        #1000000;
        num_errors++;
        tally_and_finish();
    end
endmodule : can_selective_wakeup_filter_bench

// File: testbench/wake_filter_props.sv
`timescale 1ns/1ns
module wake_filter_props (
    // Clock, reset and register port
    input wire logic sys_clk_in, input wire logic rst_in, input wire logic [6:0] reg_addr_in,
    input wire logic reg_wr_in, input wire logic reg_rd_in, input wire logic [7:0] reg_rdata_out,
    // Mode and results
    input wire logic [2:0] chip_operating_mode_in, input wire logic [1:0] transceiver_mode_out,
    input wire logic selective_active_out, input wire logic selective_wake_frame_out,
    input wire logic frame_detect_error_event_out, input wire logic standby_request_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_gate; $past(chip_operating_mode_in) != 3'h7 |-> !transceiver_mode_out; endproperty
    a_gate: assert property (p_gate) else $error("mode gate");
    property p_code; transceiver_mode_out != 2'h2; endproperty
    a_code: assert property (p_code) else $error("mode code");
    property p_sb; standby_request_out |-> frame_detect_error_event_out; endproperty
    a_sb: assert property (p_sb) else $error("standby");
    property p_fde; frame_detect_error_event_out |=> !frame_detect_error_event_out; endproperty
    a_fde: assert property (p_fde) else $error("event pulse");
    property p_wake;
        selective_wake_frame_out |-> $past(selective_active_out) ##1 !selective_wake_frame_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake gate");
    property p_clr;
        reg_wr_in && reg_addr_in inside {[7'h26:7'h2f], [7'h68:7'h6f]} |-> ##2 !selective_active_out;
    endproperty
    a_clr: assert property (p_clr) else $error("valid clear");
    property p_st; reg_rd_in && reg_addr_in == 7'h22 |=> (reg_rdata_out[6] || reg_rdata_out[5])
        && !reg_rdata_out[2] && !(reg_rdata_out[7] && reg_rdata_out[0]); endproperty
    a_st: assert property (p_st) else $error("status bits");
    property p_idr; reg_rd_in && reg_addr_in == 7'h2a |=> reg_rdata_out[7:5] == 3'h0; endproperty
    a_idr: assert property (p_idr) else $error("id reserved");
    c_wake: cover property (selective_wake_frame_out);
    c_fde: cover property (frame_detect_error_event_out);
    c_sb: cover property (standby_request_out);
endmodule : wake_filter_props
bind can_selective_wakeup_filter wake_filter_props wake_filter_props_inst (.sys_clk_in, .rst_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .chip_operating_mode_in,
    .transceiver_mode_out, .selective_active_out, .selective_wake_frame_out,
    .frame_detect_error_event_out, .standby_request_out);
